// ---- verilog/hpdma_defs.svh ----
// Constants for the host memory port
`ifndef HPDMA_DEFS_SVH
`define HPDMA_DEFS_SVH
`define HPDMA_START_ADDR_OFFSET 14'h3fe0
`define HPDMA_CTRL_REG_BASE 14'h3fe0
`define HPDMA_TYPE_BIT 14
`define HPDMA_ADDR_MSB 13
`define HPDMA_BOOT_MODE 3'h5
`define HPDMA_FIFO_DEPTH 4
`define HPDMA_ZERO_ADDR 14'h0000
`endif

// ---- verilog/hpdma_pkg.sv ----
// Types for the host memory port
package hpdma_pkg;
   typedef enum logic [2:0] {
      HPDMA_IDLE = 3'b000,
      HPDMA_SYNC = 3'b001,
      HPDMA_ACCESS = 3'b010,
      HPDMA_WAIT_REL = 3'b011
   } hpdma_state_t;
   typedef struct packed {
      hpdma_state_t state;
      logic [14:0] start_address;
      logic hi_done;
      logic [15:0] pm_low;
      logic is_write;
      logic [15:0] rdata;
      logic ack;
      logic bus_oe;
      logic [15:0] bus_out;
      logic al_prev;
      logic boot_hold;
      logic boot_sampled;
      logic mem_we;
      logic mem_re;
      logic mem_pm;
      logic [13:0] mem_addr;
      logic [23:0] mem_wdata;
   } hpdma_regs_t;
endpackage

// ---- verilog/hpdma_fifo.sv ----
// Small valid/ready FIFO
module hpdma_fifo #(
   parameter int WIDTH = 40,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wp_reg;
   logic [AW-1:0] rp_reg;
   logic [AW:0] cnt_reg;
   logic push;
   logic pop;
   assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_reg != '0);
   assign out_data_o = mem_reg[rp_reg];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wp_reg <= '0;
         rp_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
         end
         if (pop) begin
            rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
         end
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_reg[wp_reg] <= in_data_i;
      end
   end
endmodule

// ---- verilog/hpdma_port.sv ----
// Host memory access port with boot hold
`include "hpdma_defs.svh"
// Summary of operation
// - Host reaches program and data memory with one processor cycle per word, except program memory words, which take two for both reads and writes.
// - Host writes to the control register area are dropped.
// - One 16-bit multiplexed bus carries address and data, including 24-bit words.
// - Strobes are accepted at any time while the processor runs.
// - The latched address increments after each completed data memory access and after the second access of a program memory word.
// - The address phase carries a 14-bit address and one memory type bit.
// - Address and type are captured on the falling edge of address latch.
// - A request takes one cycle to synchronise and one cycle to access memory.
// - The start address register is also writable by the processor at its mapped address.
// - The host cannot read the start address back.
// - Boot through this port when mode pins are C=1, B=0, A=1.
// - In that boot mode execution stalls until program location 0 is written.
module hpdma_port
   import hpdma_pkg::*;
#(
   parameter int FIFO_DEPTH = `HPDMA_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Host pins
   input wire logic host_port_select_n_i,
   input wire logic host_address_latch_i,
   input wire logic host_read_strobe_n_i,
   input wire logic host_write_strobe_n_i,
   input wire logic [15:0] host_addr_data_bus_i,
   output logic [15:0] host_addr_data_bus_o,
   output logic host_addr_data_bus_oe_o,
   output logic host_port_ack_o,
   // Boot mode pins
   input wire logic [2:0] boot_mode_i,
   output logic exec_hold_o,
   // Processor write and read of start address
   input wire logic cpu_start_we_i,
   input wire logic [15:0] cpu_start_wdata_i,
   output logic [15:0] cpu_start_rdata_o,
   // Memory side write path
   output logic mem_we_o,
   output logic mem_pm_o,
   output logic [13:0] mem_addr_o,
   output logic [23:0] mem_wdata_o,
   // Memory side read path
   output logic mem_re_o,
   input wire logic [23:0] mem_rdata_i
);
   hpdma_regs_t r_reg;
   hpdma_regs_t r_next;
   logic [15:0] bus_s_reg;
   logic sel_s_reg;
   logic rd_s_reg;
   logic wr_s_reg;
   logic al_s_reg;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [46:0] fifo_out_data;
   logic fifo_pop;
   logic [46:0] fifo_in_data;
   logic fifo_push;

   // Control register area check
   function automatic logic is_ctrl_area(input logic pm, input logic [13:0] a);
      is_ctrl_area = !pm && (a >= `HPDMA_CTRL_REG_BASE);
   endfunction

   // Strobe synchroniser stage
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sel_s_reg <= 1'b0;
         rd_s_reg <= 1'b0;
         wr_s_reg <= 1'b0;
         al_s_reg <= 1'b0;
         bus_s_reg <= 16'h0000;
      end else begin
         sel_s_reg <= !host_port_select_n_i;
         rd_s_reg <= !host_read_strobe_n_i;
         wr_s_reg <= !host_write_strobe_n_i;
         al_s_reg <= host_address_latch_i;
         bus_s_reg <= host_addr_data_bus_i;
      end
   end

   // Write words queue before memory
   assign fifo_in_data = {r_reg.start_address, r_reg.pm_low, host_word()};
   function automatic logic [15:0] host_word();
      host_word = bus_s_reg;
   endfunction
   assign fifo_pop = fifo_out_valid;

   hpdma_fifo #(.WIDTH(47), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .in_valid_i(fifo_push),
      .in_ready_o(fifo_in_ready),
      .in_data_i(fifo_in_data),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(1'b1),
      .out_data_o(fifo_out_data)
   );

   always_comb begin
      r_next = r_reg;
      fifo_push = 1'b0;
      r_next.mem_we = 1'b0;
      r_next.mem_re = 1'b0;
      r_next.al_prev = al_s_reg;
      if (!r_reg.boot_sampled) begin
         r_next.boot_sampled = 1'b1;
         r_next.boot_hold = (boot_mode_i == `HPDMA_BOOT_MODE);
      end
      // Address latch on falling edge of latch strobe
      if (sel_s_reg && r_reg.al_prev && !al_s_reg) begin
         r_next.start_address = bus_s_reg[`HPDMA_TYPE_BIT:0];
         r_next.hi_done = 1'b0;
      end
      if (cpu_start_we_i) begin
         r_next.start_address = cpu_start_wdata_i[`HPDMA_TYPE_BIT:0];
         r_next.hi_done = 1'b0;
      end
      // Drain queued writes into memory, one cycle each
      if (fifo_pop) begin
         r_next.mem_pm = fifo_out_data[46];
         r_next.mem_addr = fifo_out_data[45:32];
         r_next.mem_wdata = fifo_out_data[46] ? {fifo_out_data[31:16], fifo_out_data[7:0]}
                                              : {8'h00, fifo_out_data[15:0]};
         r_next.mem_we = !is_ctrl_area(fifo_out_data[46], fifo_out_data[45:32]);
         if (fifo_out_data[46] && fifo_out_data[45:32] == `HPDMA_ZERO_ADDR) begin
            r_next.boot_hold = 1'b0;
         end
      end
      case (r_reg.state)
         HPDMA_IDLE: begin
            r_next.ack = fifo_in_ready;
            if (sel_s_reg && (rd_s_reg || wr_s_reg) && fifo_in_ready) begin
               r_next.is_write = wr_s_reg;
               r_next.ack = 1'b0;
               r_next.state = HPDMA_SYNC;
            end
         end
         HPDMA_SYNC: begin
            r_next.state = HPDMA_ACCESS;
            if (!r_reg.is_write) begin
               r_next.mem_re = 1'b1;
               r_next.mem_pm = r_reg.start_address[`HPDMA_TYPE_BIT];
               r_next.mem_addr = r_reg.start_address[`HPDMA_ADDR_MSB:0];
            end
         end
         HPDMA_ACCESS: begin
            r_next.state = HPDMA_WAIT_REL;
            r_next.ack = 1'b1;
            if (r_reg.is_write) begin
               if (r_reg.start_address[`HPDMA_TYPE_BIT] && !r_reg.hi_done) begin
                  r_next.pm_low = bus_s_reg;
                  r_next.hi_done = 1'b1;
               end else begin
                  fifo_push = 1'b1;
                  r_next.hi_done = 1'b0;
                  r_next.start_address[`HPDMA_ADDR_MSB:0] =
                     r_reg.start_address[`HPDMA_ADDR_MSB:0] + 14'h0001;
               end
            end else begin
               // Read data returned, never the start address
               if (r_reg.start_address[`HPDMA_TYPE_BIT] && !r_reg.hi_done) begin
                  r_next.rdata = mem_rdata_i[23:8];
                  r_next.hi_done = 1'b1;
               end else begin
                  r_next.rdata = r_reg.start_address[`HPDMA_TYPE_BIT] ? {8'h00, mem_rdata_i[7:0]}
                                                                     : mem_rdata_i[15:0];
                  r_next.hi_done = 1'b0;
                  r_next.start_address[`HPDMA_ADDR_MSB:0] =
                     r_reg.start_address[`HPDMA_ADDR_MSB:0] + 14'h0001;
               end
               r_next.bus_out = r_next.rdata;
               r_next.bus_oe = 1'b1;
            end
         end
         HPDMA_WAIT_REL: begin
            if (!(rd_s_reg || wr_s_reg) || !sel_s_reg) begin
               r_next.bus_oe = 1'b0;
               r_next.state = HPDMA_IDLE;
            end
         end
         default: begin
            r_next.state = HPDMA_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         r_reg <= '{state: HPDMA_IDLE, boot_hold: 1'b1, default: '0};
      end else begin
         r_reg <= r_next;
      end
   end

   assign host_addr_data_bus_o = r_reg.bus_out;
   assign host_addr_data_bus_oe_o = r_reg.bus_oe;
   assign host_port_ack_o = r_reg.ack;
   assign exec_hold_o = r_reg.boot_hold;
   assign cpu_start_rdata_o = {1'b0, r_reg.start_address};
   assign mem_we_o = r_reg.mem_we;
   assign mem_re_o = r_reg.mem_re;
   assign mem_pm_o = r_reg.mem_pm;
   assign mem_addr_o = r_reg.mem_addr;
   assign mem_wdata_o = r_reg.mem_wdata;
endmodule

// ---- verification/hpdma_checker.sv ----
// Assertions on the host memory port pins
module hpdma_checker
   import hpdma_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Host pins
   input wire logic host_port_select_n_i,
   input wire logic host_address_latch_i,
   input wire logic host_read_strobe_n_i,
   input wire logic host_write_strobe_n_i,
   input wire logic [15:0] host_addr_data_bus_i,
   input wire logic [15:0] host_addr_data_bus_o,
   input wire logic host_addr_data_bus_oe_o,
   input wire logic host_port_ack_o,
   // Boot and processor side
   input wire logic [2:0] boot_mode_i,
   input wire logic exec_hold_o,
   input wire logic cpu_start_we_i,
   input wire logic [15:0] cpu_start_wdata_i,
   input wire logic [15:0] cpu_start_rdata_o,
   // Memory side
   input wire logic mem_we_o,
   input wire logic mem_pm_o,
   input wire logic [13:0] mem_addr_o,
   input wire logic [23:0] mem_wdata_o,
   input wire logic mem_re_o,
   input wire logic [23:0] mem_rdata_i
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   property p_rd_ans; mem_re_o |=> host_port_ack_o && host_addr_data_bus_oe_o; endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
   property p_re_pulse; mem_re_o |=> !mem_re_o; endproperty
   a_re_pulse: assert property (p_re_pulse) else $error("read strobe too long");
   property p_ctrl; mem_we_o && !mem_pm_o |-> mem_addr_o < 14'h3fe0; endproperty
   a_ctrl: assert property (p_ctrl) else $error("control area written");
   property p_req; $fell(host_read_strobe_n_i) && !host_port_select_n_i |-> ##[1:4] mem_re_o; endproperty
   a_req: assert property (p_req) else $error("read not started");
   property p_oe_rel; $rose(host_read_strobe_n_i) |-> ##[1:3] !host_addr_data_bus_oe_o; endproperty
   a_oe_rel: assert property (p_oe_rel) else $error("bus not released");
   property p_hold_rel; mem_we_o && mem_pm_o && mem_addr_o == 14'h0000 |-> ##[0:2] !exec_hold_o; endproperty
   a_hold_rel: assert property (p_hold_rel) else $error("hold not released");
   property p_hold_stay; !exec_hold_o |=> !exec_hold_o; endproperty
   a_hold_stay: assert property (p_hold_stay) else $error("hold came back");
   property p_cpu_b15; !cpu_start_rdata_o[15]; endproperty
   a_cpu_b15: assert property (p_cpu_b15) else $error("start bit 15 set");
endmodule

// ---- verification/hpdma_mem_model.sv ----
// Memory model answering the port's memory strobes
module hpdma_mem_model (
   // Clock
   input wire logic clk_i,
   // Memory strobes
   input wire logic we_i,
   input wire logic re_i,
   input wire logic pm_i,
   input wire logic [13:0] addr_i,
   input wire logic [23:0] wdata_i,
   output logic [23:0] rdata_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [23:0] pm [16384];
   logic [23:0] dm [16384];
   logic [23:0] word;
   initial begin
      foreach (dm[i]) begin
         dm[i] = 24'h000000;
         pm[i] = 24'h000000;
      end
   end
   always @(posedge clk_i) begin
      if (we_i && pm_i) pm[addr_i] <= wdata_i;
      if (we_i && !pm_i) dm[addr_i] <= wdata_i;
   end
   // Data valid only while the read strobe stands
   assign word = pm_i ? pm[addr_i] : dm[addr_i];
   assign rdata_o = re_i ? word : ~word;
endmodule

// ---- verification/host_internal_memory_dma_port_tb_top.sv ----
// Testbench of the host memory port
module host_internal_memory_dma_port_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 0, arst_n_i = 0, host_port_select_n_i = 1, host_address_latch_i = 0;
   logic host_read_strobe_n_i = 1, host_write_strobe_n_i = 1, cpu_start_we_i = 0;
   logic [15:0] host_addr_data_bus_i = 16'h0000, cpu_start_wdata_i = 16'h0000, host_addr_data_bus_o, rd;
   logic host_addr_data_bus_oe_o, host_port_ack_o, exec_hold_o, mem_we_o, mem_pm_o, mem_re_o;
   logic [2:0] boot_mode_i = 3'h5;
   logic [15:0] cpu_start_rdata_o;
   logic [13:0] mem_addr_o;
   logic [23:0] mem_wdata_o, mem_rdata_i;
   int mismatches = 0, check_count = 0, cyc = 0;
   hpdma_port i_dut (.*);
   hpdma_mem_model i_mem (.clk_i(clk_i), .we_i(mem_we_o), .re_i(mem_re_o), .pm_i(mem_pm_o),
      .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         stop_test();
      end
   end
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wait_ack(input logic lvl);
      int n;
      n = 0;
      @(negedge clk_i);
      while (host_port_ack_o !== lvl && n < 50) begin
         @(negedge clk_i);
         n++;
      end
      if (n == 50) chk(24'(host_port_ack_o), 24'(lvl));
   endtask
   task automatic latch(input logic [15:0] a);
      wait_ack(1);
      @(posedge clk_i);
      host_port_select_n_i <= 0;
      host_address_latch_i <= 1;
      host_addr_data_bus_i <= a;
      repeat (3) @(posedge clk_i);
      host_address_latch_i <= 0;
      repeat (3) @(posedge clk_i);
      host_port_select_n_i <= 1;
   endtask
   task automatic acc(input logic wr, input logic [15:0] d);
      wait_ack(1);
      @(posedge clk_i);
      host_port_select_n_i <= 0;
      host_write_strobe_n_i <= !wr;
      host_read_strobe_n_i <= wr;
      host_addr_data_bus_i <= d;
      wait_ack(0);
      wait_ack(1);
      rd = host_addr_data_bus_o;
      @(posedge clk_i);
      host_port_select_n_i <= 1;
      host_write_strobe_n_i <= 1;
      host_read_strobe_n_i <= 1;
      host_addr_data_bus_i <= ~d;
      repeat (3) @(posedge clk_i);
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk_i);
      arst_n_i <= 1;
      repeat (3) @(negedge clk_i);
      chk(24'(exec_hold_o), 24'h000001);
      latch(16'h0010);
      acc(1, 16'h1234);
      acc(1, 16'h5678);
      latch(16'h0010);
      acc(0, 16'h0000);
      chk(24'(rd), 24'h001234);
      acc(0, 16'h0000);
      chk(24'(rd), 24'h005678);
      chk(24'(exec_hold_o), 24'h000001);
      $display("test data memory done");
      latch(16'h3fe1);
      acc(1, 16'hbeef);
      repeat (4) @(negedge clk_i);
      chk(i_mem.dm[14'h3fe1], 24'h000000);
      latch(16'h4000);
      acc(1, 16'habcd);
      acc(1, 16'h00ef);
      repeat (4) @(negedge clk_i);
      chk(i_mem.pm[0], 24'habcdef);
      chk(24'(exec_hold_o), 24'h000000);
      latch(16'h4000);
      acc(0, 16'h0000);
      chk(24'(rd), 24'h00abcd);
      acc(0, 16'h0000);
      chk(24'(rd[7:0]), 24'h0000ef);
      $display("test program memory done");
      @(posedge clk_i);
      cpu_start_we_i <= 1;
      cpu_start_wdata_i <= 16'h0011;
      @(posedge clk_i);
      cpu_start_we_i <= 0;
      @(negedge clk_i);
      chk(24'(cpu_start_rdata_o), 24'h000011);
      acc(0, 16'h0000);
      chk(24'(rd), 24'h005678);
      $display("test processor start done");
      stop_test();
   end
endmodule
bind hpdma_port hpdma_checker i_chk (.*);
